// [hw/sfl_link.sv]
`timescale 1ns/10ps
`default_nettype none
`include "sfl_defines.svh"

module sfl_link
  import sfl_pkg::*;
#(
  parameter int FIFO_DEPTH = `SFL_FIFO_DEPTH
)
(
  input  wire logic       CLOCK_IN,
  input  wire logic       RESET_IN,
  input  wire logic       SPI_CLK_IN,
  input  wire logic       SPI_CS_N_IN,
  input  wire logic       SPI_MOSI_IN,
  output logic            SPI_MISO_OUT,
  output logic            SPI_MISO_OE_N_OUT,
  input  wire logic       BINARY_PAGE_IN,
  output logic [8:0]      PAGE_SIZE_OUT,
  output logic [7:0]      RX_DATA_OUT,
  output logic            RX_FIRST_OUT,
  output logic            RX_VALID_OUT,
  input  wire logic       RX_READY_IN,
  input  wire logic [7:0] TX_DATA_IN,
  input  wire logic       TX_VALID_IN,
  output logic            TX_READY_OUT,
  output logic [4:0]      CMD_KIND_OUT,
  output logic            OVERRUN_OUT
);

  // ---------------- Link domain, clocked by the host's serial clock
  logic [2:0] bit_reg;
  logic [2:0] bit_next;
  logic [6:0] sh_reg;
  logic [6:0] sh_next;
  logic [3:0] hdr_reg;
  logic [3:0] hdr_next;
  sfl_link_t  st_reg;
  sfl_link_t  st_next;
  logic       first_reg;
  logic       first_next;
  logic [7:0] rx_byte_reg;
  logic [7:0] rx_byte_next;
  logic       rx_first_reg;
  logic       rx_first_next;
  logic       rx_tgl_reg;
  logic       rx_tgl_next;
  logic       ack_reg;
  logic       ack_next;
  logic [7:0] tx_byte_reg;
  logic [7:0] tx_byte_next;
  logic       req_s1_reg;
  logic       req_s2_reg;
  logic [7:0] out_reg;
  logic [7:0] out_next;
  logic       drv_reg;
  logic       drv_next;
  logic [7:0] full_byte;
  logic       byte_done;
  logic       fresh;
  sfl_cmd_t   kind;

  // ---------------- Core domain
  logic [7:0] hold_reg;
  logic [7:0] hold_next;
  logic       req_reg;
  logic       req_next;
  logic       ack_s1_reg;
  logic       ack_s2_reg;
  logic       rx_s1_reg;
  logic       rx_s2_reg;
  logic       rx_s3_reg;
  logic       rx_event;
  logic       fifo_ready;
  logic [8:0] fifo_out;
  logic [4:0] cmd_reg;
  logic [4:0] cmd_next;
  logic       ovr_reg;
  logic       ovr_next;
  logic       strap_s1_reg;
  logic       strap_s2_reg;
  logic       strap_done_reg;
  logic       strap_done_next;
  logic [8:0] page_reg;
  logic [8:0] page_next;

  assign full_byte = {sh_reg, SPI_MOSI_IN};
  assign byte_done = (bit_reg == 3'h7);
  assign kind      = sfl_decode(full_byte);
  assign fresh     = (req_s2_reg != ack_reg);

  // Rising-edge receive path: the host launched this bit on the previous
  // rising edge, so a whole period of setup is seen here. Mode 0 and
  // mode 3 look the same because only rising edges are counted.
  always_comb
  begin
    bit_next      = bit_reg + 3'h1;
    sh_next       = full_byte[6:0];
    hdr_next      = hdr_reg;
    st_next       = st_reg;
    first_next    = first_reg;
    rx_byte_next  = rx_byte_reg;
    rx_first_next = rx_first_reg;
    rx_tgl_next   = rx_tgl_reg;
    ack_next      = ack_reg;
    tx_byte_next  = tx_byte_reg;
    if (byte_done)
    begin
      // Byte stays stable a whole byte time for the core to pick it up
      rx_byte_next  = full_byte;
      rx_first_next = first_reg;
      rx_tgl_next   = ~rx_tgl_reg;
      first_next    = 1'b0;
      case (st_reg)
        SFL_LK_OPCODE:
        begin
          hdr_next = sfl_hdr_len(kind);
          if (kind == SFL_CMD_NONE)
            st_next = SFL_LK_IGNORE;
          else if (sfl_hdr_len(kind) == 4'h0)
            st_next = SFL_LK_DATA;
          else
            st_next = SFL_LK_HEADER;
        end
        SFL_LK_HEADER:
        begin
          hdr_next = hdr_reg - 4'h1;
          if (hdr_reg == 4'h1)
            st_next = SFL_LK_DATA;
        end
        SFL_LK_DATA:   st_next = SFL_LK_DATA;
        SFL_LK_IGNORE: st_next = SFL_LK_IGNORE;
        default:       st_next = SFL_LK_IGNORE;
      endcase
      // Fetch the next response byte; an empty hold sends idle ones
      if (st_next == SFL_LK_DATA)
      begin
        tx_byte_next = fresh ? hold_reg : `SFL_IDLE_BYTE;
        ack_next     = fresh ? ~ack_reg : ack_reg;
      end
    end
  end

  // Frame state: raising select ends the command, the clock may stop
  always_ff @(posedge SPI_CLK_IN or posedge SPI_CS_N_IN)
  begin
    if (SPI_CS_N_IN)
    begin
      bit_reg   <= 3'h0;
      sh_reg    <= 7'h00;
      hdr_reg   <= 4'h0;
      st_reg    <= SFL_LK_OPCODE;
      first_reg <= 1'b1;
    end
    else
    begin
      bit_reg   <= bit_next;
      sh_reg    <= sh_next;
      hdr_reg   <= hdr_next;
      st_reg    <= st_next;
      first_reg <= first_next;
    end
  end

  // Handshake state lives across frames, so only the block reset clears
  // it; clearing on select would fake a toggle toward the core
  always_ff @(posedge SPI_CLK_IN or posedge RESET_IN)
  begin
    if (RESET_IN)
    begin
      rx_byte_reg  <= 8'h00;
      rx_first_reg <= 1'b0;
      rx_tgl_reg   <= 1'b0;
      ack_reg      <= 1'b0;
      tx_byte_reg  <= 8'hFF;
      req_s1_reg   <= 1'b0;
      req_s2_reg   <= 1'b0;
    end
    else
    begin
      rx_byte_reg  <= rx_byte_next;
      rx_first_reg <= rx_first_next;
      rx_tgl_reg   <= rx_tgl_next;
      ack_reg      <= ack_next;
      tx_byte_reg  <= tx_byte_next;
      req_s1_reg   <= req_reg;
      req_s2_reg   <= req_s1_reg;
    end
  end

  // Falling-edge transmit path: a new bit appears at the start of the
  // low phase, so it is valid before the clock rises and the host has a
  // whole cycle until the next falling edge to take it.
  always_comb
  begin
    out_next = out_reg;
    drv_next = drv_reg;
    if (st_reg == SFL_LK_DATA)
    begin
      drv_next = 1'b1;
      if (bit_reg == 3'h0)
        out_next = tx_byte_reg;
      else
        out_next = {out_reg[6:0], 1'b0};
    end
  end

  always_ff @(negedge SPI_CLK_IN or posedge SPI_CS_N_IN)
  begin
    if (SPI_CS_N_IN)
    begin
      out_reg <= 8'hFF;
      drv_reg <= 1'b0;
    end
    else
    begin
      out_reg <= out_next;
      drv_reg <= drv_next;
    end
  end

  // Pin released the moment select rises
  assign SPI_MISO_OUT      = out_reg[7];
  assign SPI_MISO_OE_N_OUT = ~drv_reg;

  // ---------------- Core side
  // The first synchroniser stage feeds only the second
  assign rx_event = rx_s2_reg ^ rx_s3_reg;

  // Hold register pairs with a toggle request; it is stable whenever
  // the link sees the request differ from its acknowledge
  assign TX_READY_OUT = (req_reg == ack_s2_reg);

  always_comb
  begin
    hold_next = hold_reg;
    req_next  = req_reg;
    cmd_next  = cmd_reg;
    ovr_next  = ovr_reg;
    if (TX_VALID_IN && TX_READY_OUT)
    begin
      hold_next = TX_DATA_IN;
      req_next  = ~req_reg;
    end
    if (rx_event && rx_first_reg)
      cmd_next = sfl_decode(rx_byte_reg);
    // The host cannot be stalled, so a full buffer loses the byte
    if (rx_event && !fifo_ready)
      ovr_next = 1'b1;
  end

  always_ff @(posedge CLOCK_IN)
  begin
    if (RESET_IN)
    begin
      hold_reg   <= 8'hFF;
      req_reg    <= 1'b0;
      ack_s1_reg <= 1'b0;
      ack_s2_reg <= 1'b0;
      rx_s1_reg  <= 1'b0;
      rx_s2_reg  <= 1'b0;
      rx_s3_reg  <= 1'b0;
      cmd_reg    <= SFL_CMD_NONE;
      ovr_reg    <= 1'b0;
    end
    else
    begin
      hold_reg   <= hold_next;
      req_reg    <= req_next;
      ack_s1_reg <= ack_reg;
      ack_s2_reg <= ack_s1_reg;
      rx_s1_reg  <= rx_tgl_reg;
      rx_s2_reg  <= rx_s1_reg;
      rx_s3_reg  <= rx_s2_reg;
      cmd_reg    <= cmd_next;
      ovr_reg    <= ovr_next;
    end
  end

  assign CMD_KIND_OUT = cmd_reg;
  assign OVERRUN_OUT  = ovr_reg;

  // Page size strap is caught on the first edge after reset release
  always_comb
  begin
    strap_done_next = 1'b1;
    page_next       = page_reg;
    if (!strap_done_reg)
      page_next = strap_s2_reg ? `SFL_PAGE_BINARY
                               : `SFL_PAGE_EXTENDED;
  end

  always_ff @(posedge CLOCK_IN)
  begin
    strap_s1_reg <= BINARY_PAGE_IN;
    strap_s2_reg <= strap_s1_reg;
    if (RESET_IN)
    begin
      strap_done_reg <= 1'b0;
      page_reg       <= `SFL_PAGE_EXTENDED;
    end
    else
    begin
      strap_done_reg <= strap_done_next;
      page_reg       <= page_next;
    end
  end

  assign PAGE_SIZE_OUT = page_reg;

  // Received bytes, opcode marked, buffered toward the user
  sfl_fifo #(
    .WIDTH (`SFL_FIFO_WIDTH),
    .DEPTH (FIFO_DEPTH)
  ) u_rx_fifo (
    .clk_in        (CLOCK_IN),
    .rst_in        (RESET_IN),
    .in_data_in    ({rx_first_reg, rx_byte_reg}),
    .in_valid_in   (rx_event),
    .in_ready_out  (fifo_ready),
    .out_data_out  (fifo_out),
    .out_valid_out (RX_VALID_OUT),
    .out_ready_in  (RX_READY_IN)
  );

  assign RX_DATA_OUT  = fifo_out[7:0];
  assign RX_FIRST_OUT = fifo_out[8];

endmodule
`default_nettype wire

// [hw/sfl_defines.svh]
`ifndef SFL_DEFINES_SVH
`define SFL_DEFINES_SVH

`define SFL_OP_ARRAY_READ  8'hE8
`define SFL_OP_PAGE_READ   8'hD2
`define SFL_OP_STATUS_READ 8'hD7
`define SFL_OP_LOCK_READ   8'h35

// Address and dummy bytes between opcode and first response byte
`define SFL_HDR_ARRAY      4'h7
`define SFL_HDR_PAGE       4'h7
`define SFL_HDR_STATUS     4'h0
`define SFL_HDR_LOCK       4'h3

`define SFL_PAGE_BINARY    9'h100
`define SFL_PAGE_EXTENDED  9'h108
`define SFL_IDLE_BYTE      8'hFF
`define SFL_FIFO_DEPTH     8
`define SFL_FIFO_WIDTH     9

`endif

// [hw/sfl_pkg.sv]
`include "sfl_defines.svh"

package sfl_pkg;

  typedef enum logic [4:0] {
    SFL_CMD_NONE   = 5'h01,
    SFL_CMD_ARRAY  = 5'h02,
    SFL_CMD_PAGE   = 5'h04,
    SFL_CMD_STATUS = 5'h08,
    SFL_CMD_LOCK   = 5'h10
  } sfl_cmd_t;

  typedef enum logic [3:0] {
    SFL_LK_OPCODE = 4'h1,
    SFL_LK_HEADER = 4'h2,
    SFL_LK_DATA   = 4'h4,
    SFL_LK_IGNORE = 4'h8
  } sfl_link_t;

  // Opcode decode shared by the link and the core side
  function automatic sfl_cmd_t sfl_decode(input logic [7:0] op);
    sfl_cmd_t k;
    k = SFL_CMD_NONE;
    case (op)
      `SFL_OP_ARRAY_READ:  k = SFL_CMD_ARRAY;
      `SFL_OP_PAGE_READ:   k = SFL_CMD_PAGE;
      `SFL_OP_STATUS_READ: k = SFL_CMD_STATUS;
      `SFL_OP_LOCK_READ:   k = SFL_CMD_LOCK;
      default:             k = SFL_CMD_NONE;
    endcase
    return k;
  endfunction

  function automatic logic [3:0] sfl_hdr_len(input sfl_cmd_t k);
    logic [3:0] n;
    n = 4'h0;
    case (k)
      SFL_CMD_ARRAY:  n = `SFL_HDR_ARRAY;
      SFL_CMD_PAGE:   n = `SFL_HDR_PAGE;
      SFL_CMD_STATUS: n = `SFL_HDR_STATUS;
      SFL_CMD_LOCK:   n = `SFL_HDR_LOCK;
      default:        n = 4'h0;
    endcase
    return n;
  endfunction

endpackage

// [hw/sfl_fifo.sv]
`timescale 1ns/10ps
`default_nettype none

module sfl_fifo
  import sfl_pkg::*;
#(
  parameter int WIDTH = 9,
  parameter int DEPTH = 8
)
(
  input  wire logic             clk_in,
  input  wire logic             rst_in,
  input  wire logic [WIDTH-1:0] in_data_in,
  input  wire logic             in_valid_in,
  output logic                  in_ready_out,
  output logic      [WIDTH-1:0] out_data_out,
  output logic                  out_valid_out,
  input  wire logic             out_ready_in
);

  localparam int AW = (DEPTH > 1) ? $clog2(DEPTH) : 1;

  logic [WIDTH-1:0] mem_reg [DEPTH];
  logic [AW-1:0]    wr_reg;
  logic [AW-1:0]    wr_next;
  logic [AW-1:0]    rd_reg;
  logic [AW-1:0]    rd_next;
  logic [AW:0]      cnt_reg;
  logic [AW:0]      cnt_next;
  logic             push;
  logic             pop;

  // Honest flags straight from the fill count
  assign in_ready_out  = (cnt_reg != (AW+1)'(DEPTH));
  assign out_valid_out = (cnt_reg != '0);
  assign out_data_out  = mem_reg[rd_reg];
  assign push          = in_valid_in && in_ready_out;
  assign pop           = out_valid_out && out_ready_in;

  // Pointers wrap explicitly so any depth works, not only powers of two
  always_comb
  begin
    wr_next  = wr_reg;
    rd_next  = rd_reg;
    cnt_next = cnt_reg;
    if (push)
      wr_next = (wr_reg == AW'(DEPTH-1)) ? '0 : wr_reg + 1'b1;
    if (pop)
      rd_next = (rd_reg == AW'(DEPTH-1)) ? '0 : rd_reg + 1'b1;
    if (push && !pop)
      cnt_next = cnt_reg + 1'b1;
    else if (pop && !push)
      cnt_next = cnt_reg - 1'b1;
  end

  always_ff @(posedge clk_in)
  begin
    if (rst_in)
    begin
      wr_reg  <= '0;
      rd_reg  <= '0;
      cnt_reg <= '0;
    end
    else
    begin
      wr_reg  <= wr_next;
      rd_reg  <= rd_next;
      cnt_reg <= cnt_next;
    end
  end

  // Storage has no reset; only words below the count are ever read
  always_ff @(posedge clk_in)
  begin
    if (push)
      mem_reg[wr_reg] <= in_data_in;
  end

endmodule
`default_nettype wire

// [verif/sfl_link_asserts.sv]
`timescale 1ns/10ps
`default_nettype none
module sfl_link_chk (
  input wire logic       CLOCK_IN,
  input wire logic       RESET_IN,
  input wire logic       SPI_CLK_IN,
  input wire logic       SPI_CS_N_IN,
  input wire logic       SPI_MOSI_IN,
  input wire logic       SPI_MISO_OUT,
  input wire logic       SPI_MISO_OE_N_OUT,
  input wire logic       BINARY_PAGE_IN,
  input wire logic [8:0] PAGE_SIZE_OUT,
  input wire logic [7:0] RX_DATA_OUT,
  input wire logic       RX_VALID_OUT,
  input wire logic       RX_READY_IN,
  input wire logic       TX_VALID_IN,
  input wire logic       TX_READY_OUT
);
  logic [7:0] cnt_reg, cnt_next, sh_reg, sh_next, op_reg, op_next, rsp;
  logic       miso_reg;
  // Bits seen in this frame and its opcode; rsp is bits before the answer
  always_comb
  begin
    cnt_next = (cnt_reg == 8'hFF) ? cnt_reg : cnt_reg + 8'h01;
    sh_next = {sh_reg[6:0], SPI_MOSI_IN};
    op_next = (cnt_reg == 8'h07) ? sh_next : op_reg;
    case (op_reg)
      8'hE8, 8'hD2: rsp = 8'h40;
      8'hD7:        rsp = 8'h08;
      8'h35:        rsp = 8'h20;
      default:      rsp = 8'h00;
    endcase
  end
  // Select high clears the frame, as in the memory itself
  always_ff @(posedge SPI_CLK_IN or posedge SPI_CS_N_IN)
  begin
    if (SPI_CS_N_IN)
    begin
      cnt_reg <= 8'h00;
      sh_reg <= 8'h00;
      op_reg <= 8'h00;
    end
    else
    begin
      cnt_reg <= cnt_next;
      sh_reg <= sh_next;
      op_reg <= op_next;
    end
  end
  // Output as it stood before the rise; a change on the rise shows here
  always_ff @(posedge SPI_CLK_IN)
    miso_reg <= SPI_MISO_OUT;
  sequence s_hdr_done;
    cnt_reg >= 8'h08 && cnt_reg == rsp;
  endsequence
  sequence s_before_answer;
    cnt_reg >= 8'h08 && (rsp == 8'h00 || cnt_reg <= rsp);
  endsequence
  property p_miso_fall;
    @(negedge SPI_CLK_IN) disable iff (SPI_CS_N_IN || RESET_IN)
      !SPI_MISO_OE_N_OUT |-> SPI_MISO_OUT == miso_reg;
  endproperty
  property p_resp_start;
    @(negedge SPI_CLK_IN) disable iff (SPI_CS_N_IN || RESET_IN)
      s_hdr_done |=> !SPI_MISO_OE_N_OUT;
  endproperty
  property p_resp_quiet;
    @(negedge SPI_CLK_IN) disable iff (SPI_CS_N_IN || RESET_IN)
      s_before_answer |-> SPI_MISO_OE_N_OUT;
  endproperty
  property p_release;
    @(posedge CLOCK_IN) disable iff (RESET_IN)
      SPI_CS_N_IN [*2] |-> SPI_MISO_OE_N_OUT;
  endproperty
  property p_page_bin;
    @(posedge CLOCK_IN) disable iff (RESET_IN)
      BINARY_PAGE_IN [*4] |-> PAGE_SIZE_OUT == 9'h100;
  endproperty
  property p_page_ext;
    @(posedge CLOCK_IN) disable iff (RESET_IN)
      !BINARY_PAGE_IN [*4] |-> PAGE_SIZE_OUT == 9'h108;
  endproperty
  property p_tx_take;
    @(posedge CLOCK_IN) disable iff (RESET_IN)
      TX_VALID_IN && TX_READY_OUT |=> !TX_READY_OUT;
  endproperty
  property p_rx_hold;
    @(posedge CLOCK_IN) disable iff (RESET_IN)
      RX_VALID_OUT && !RX_READY_IN |=> RX_VALID_OUT && $stable(RX_DATA_OUT);
  endproperty
  a_miso_fall: assert property (p_miso_fall)
    else $error("serial out moved on a rising edge");
  a_resp_start: assert property (p_resp_start)
    else $error("answer not started after header");
  a_resp_quiet: assert property (p_resp_quiet)
    else $error("serial out enabled too early");
  a_release: assert property (p_release)
    else $error("serial out driven while deselected");
  a_page_bin: assert property (p_page_bin)
    else $error("binary page size wrong");
  a_page_ext: assert property (p_page_ext)
    else $error("extended page size wrong");
  a_tx_take: assert property (p_tx_take)
    else $error("transmit ready stayed high after take");
  a_rx_hold: assert property (p_rx_hold)
    else $error("receive head changed while stalled");
endmodule
`default_nettype wire

// [verif/sfl_host_model.sv]
`timescale 1ns/10ps
`default_nettype none
// Host end of the link; its clock stands still between frames
module sfl_host_model (
  output logic      sck_out,
  output logic      cs_n_out,
  output logic      mosi_out,
  input  wire logic miso_in,
  input  wire logic oe_n_in
);
  localparam time HALF = 32;
  logic [7:0] tx_buf [0:11];
  logic [7:0] rx_buf [0:11];
  initial
  begin
    sck_out = 1'b0;
    cs_n_out = 1'b1;
    mosi_out = 1'b0;
  end
  // Launch just after each rise, sample on the following fall
  task automatic xfer(input logic mode3, input int n);
    int i;
    int b;
    sck_out = mode3;
    #HALF cs_n_out = 1'b0;
    mosi_out = tx_buf[0][7];
    #HALF sck_out = 1'b0;
    for (i = 0; i < n; i++)
    begin
      for (b = 7; b >= 0; b--)
      begin
        #HALF sck_out = 1'b1;
        #1 mosi_out = (b > 0) ? tx_buf[i][b-1] :
                      (i + 1 < n) ? tx_buf[i+1][7] : ~mosi_out;
        // Undriven line reads as the inverse, never as a kind guess
        #(HALF - 1) rx_buf[i][b] = oe_n_in ? ~miso_in : miso_in;
        sck_out = 1'b0;
      end
    end
    #HALF cs_n_out = 1'b1;
    mosi_out = ~mosi_out;
    #HALF sck_out = mode3;
  endtask
endmodule
`default_nettype wire

// [verif/test_serial_flash_full_cycle_link.sv]
`timescale 1ns/10ps
`default_nettype none
module test_serial_flash_full_cycle_link;
  logic       clk, rst, strap, rx_rdy, tx_vld, rx_on;
  logic [7:0] tx_data;
  wire        sck, cs_n, mosi, miso, oe_n, rx_first, rx_valid, tx_ready;
  wire        overrun;
  wire  [8:0] page_size;
  wire  [7:0] rx_data;
  wire  [4:0] cmd_kind;
  logic [8:0] exp_q [$];
  logic [7:0] tx_q [$];
  logic [7:0] exp_tx [0:11];
  int         err_total, comparisons, cycles, k, rw_page;
  logic [7:0] op_tab [0:4] = '{8'hE8, 8'hD2, 8'hD7, 8'h35, 8'h5A};
  int         hdr_tab [0:4] = '{7, 7, 0, 3, 0};
  logic [4:0] kind_tab [0:4] = '{5'h02, 5'h04, 5'h08, 5'h10, 5'h01};

  sfl_link #(.FIFO_DEPTH(8)) u_dut (
    .CLOCK_IN(clk), .RESET_IN(rst), .SPI_CLK_IN(sck), .SPI_CS_N_IN(cs_n),
    .SPI_MOSI_IN(mosi), .SPI_MISO_OUT(miso), .SPI_MISO_OE_N_OUT(oe_n),
    .BINARY_PAGE_IN(strap), .PAGE_SIZE_OUT(page_size),
    .RX_DATA_OUT(rx_data), .RX_FIRST_OUT(rx_first), .RX_VALID_OUT(rx_valid),
    .RX_READY_IN(rx_rdy), .TX_DATA_IN(tx_data), .TX_VALID_IN(tx_vld),
    .TX_READY_OUT(tx_ready), .CMD_KIND_OUT(cmd_kind), .OVERRUN_OUT(overrun));
  sfl_host_model host (.sck_out(sck), .cs_n_out(cs_n), .mosi_out(mosi),
    .miso_in(miso), .oe_n_in(oe_n));

  always #50 clk = ~clk;

  task automatic chk(input string nm, input logic [8:0] e,
                     input logic [8:0] g);
    comparisons++;
    if (g !== e)
    begin
      err_total++;
      $display("unexpected %s expected %h seen %h", nm, e, g);
    end
  endtask

  task automatic conclude();
    if (err_total == 0 && comparisons > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask

  // Strap is set with reset and held, so it is settled at release
  task automatic do_reset(input logic s);
    @(negedge clk);
    strap <= s;
    rst <= 1'b1;
    repeat (6) @(negedge clk);
    rst <= 1'b0;
    repeat (4) @(negedge clk);
    chk("page", s ? 9'h100 : 9'h108, page_size);
    chk("kind", 9'h001, {4'h0, cmd_kind});
    chk("ovr", 9'h000, {8'h00, overrun});
  endtask

  // One frame; full keeps only the first eight bytes as expected
  task automatic run(input int t, input int n, input logic full);
    int i;
    int h;
    h = 1 + hdr_tab[t];
    for (i = 0; i < n; i++)
    begin
      // Ignored frames carry the host's rewrite page pointer as address
      host.tx_buf[i] = (i == 0) ? op_tab[t] : 8'($urandom);
      if (t == 4 && i > 0 && i < 4)
        host.tx_buf[i] = 8'(rw_page >> (8 * (3 - i)));
      if (!full || i < 8)
        exp_q.push_back({i == 0, host.tx_buf[i]});
      exp_tx[i] = 8'($urandom);
      if (i >= h && kind_tab[t] != 5'h01)
        tx_q.push_back(exp_tx[i]);
    end
    repeat (4) @(negedge clk);
    host.xfer(t[0], n);
    if (t == 4)
      rw_page++;
    repeat (30) @(negedge clk);
    chk("kind", {4'h0, kind_tab[t]}, {4'h0, cmd_kind});
    for (i = h; i < n && kind_tab[t] != 5'h01; i++)
      chk("miso", {1'b0, exp_tx[i]}, {1'b0, host.rx_buf[i]});
  endtask

  // Inputs change on the falling edge only
  always @(negedge clk)
  begin
    rx_rdy <= rx_on & 1'($urandom);
    tx_vld <= (tx_q.size() > 0);
    if (tx_q.size() > 0)
      tx_data <= tx_q[0];
  end

  // Takes and pops are judged on the values seen at the rising edge
  always @(posedge clk)
  begin
    if (!rst && tx_vld && tx_ready)
      void'(tx_q.pop_front());
    if (!rst && rx_valid && rx_rdy && exp_q.size() == 0)
      chk("rx", 9'hXXX, {rx_first, rx_data});
    else if (!rst && rx_valid && rx_rdy)
      chk("rx", exp_q.pop_front(), {rx_first, rx_data});
  end

  always @(posedge clk)
  begin
    cycles++;
    if (cycles == 20000)
    begin
      err_total++;
      conclude();
    end
  end

  initial
  begin
    clk = 1'b0;
    rst = 1'b1;
    strap = 1'b0;
    rx_rdy = 1'b0;
    tx_vld = 1'b0;
    tx_data = 8'h00;
    rx_on = 1'b1;
    err_total = 0;
    comparisons = 0;
    cycles = 0;
    rw_page = 0;
    void'($urandom(75));
    do_reset(1'b1);
    for (k = 0; k < 5; k++)
      run(k, 3 + hdr_tab[k], 1'b0);
    rx_on = 1'b0;
    run(4, 10, 1'b1);
    chk("ovr", 9'h001, {8'h00, overrun});
    rx_on = 1'b1;
    repeat (40) @(negedge clk);
    chk("left", 9'h000, 9'(exp_q.size()));
    chk("valid", 9'h000, {8'h00, rx_valid});
    do_reset(1'b0);
    run(3, 6, 1'b0);
    // A byte lost at the very end would otherwise go unnoticed
    repeat (40) @(negedge clk);
    chk("left", 9'h000, 9'(exp_q.size()));
    chk("txleft", 9'h000, 9'(tx_q.size()));
    conclude();
  end
endmodule

bind sfl_link sfl_link_chk u_chk (
  .CLOCK_IN(CLOCK_IN), .RESET_IN(RESET_IN), .SPI_CLK_IN(SPI_CLK_IN),
  .SPI_CS_N_IN(SPI_CS_N_IN), .SPI_MOSI_IN(SPI_MOSI_IN),
  .SPI_MISO_OUT(SPI_MISO_OUT), .SPI_MISO_OE_N_OUT(SPI_MISO_OE_N_OUT),
  .BINARY_PAGE_IN(BINARY_PAGE_IN), .PAGE_SIZE_OUT(PAGE_SIZE_OUT),
  .RX_DATA_OUT(RX_DATA_OUT), .RX_VALID_OUT(RX_VALID_OUT),
  .RX_READY_IN(RX_READY_IN), .TX_VALID_IN(TX_VALID_IN),
  .TX_READY_OUT(TX_READY_OUT));
`default_nettype wire
